/* hdl/system_debug_id_options.v */
`timescale 1ns/1ps
`default_nettype none
`include "sys_regs_defines.vh"

module system_debug_id_options #(
	parameter [11:0] PART_NUMBER = 12'h000 // arbitrary value
) (
	// clock and resets
	input wire sys_clk,
	input wire reset_n,
	input wire por_n,
	// cpu register port
	input wire [15:0] cpu_addr,
	input wire cpu_wr,
	input wire cpu_rd,
	input wire [7:0] cpu_wdata,
	output reg [7:0] cpu_rdata,
	// background debug register port
	input wire [15:0] debug_addr,
	input wire debug_wr,
	input wire [7:0] debug_wdata,
	// reset request
	output wire force_reset_req,
	// stop instruction handling
	input wire stop_exec,
	output wire stop_enter,
	output wire illegal_stop_reset,
	// pin routing
	output wire serial_pin_select,
	output wire serial_on_port_a_pin2_pin3,
	output wire timer1_pin_select,
	output wire timer0_pin_select,
	output wire [1:0] timer_zero_ch0_pin,
	output wire [1:0] timer_zero_ch1_pin,
	output wire debug_pin_enable,
	output wire port_a_pin4_output_only,
	output wire reset_pin_enable,
	output wire fast_wakeup_enable,
	output wire stop_enable
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire cpu_opt_wr; // cpu write to options
	wire dbg_opt_wr; // debug write to options
	wire opt_wr; // any options write
	wire [7:0] opt_wdata; // data for options write
	wire dbg_force_wr; // debug write to force reset

	// cpu writes to force reset register decode to nothing
	assign cpu_opt_wr = cpu_wr && (cpu_addr == `ADDR_SYSTEM_OPTIONS_ONE);
	assign dbg_opt_wr = debug_wr && (debug_addr == `ADDR_SYSTEM_OPTIONS_ONE);
	assign opt_wr = cpu_opt_wr | dbg_opt_wr;
	assign opt_wdata = dbg_opt_wr ? debug_wdata : cpu_wdata;
	assign dbg_force_wr = debug_wr && (debug_addr == `ADDR_DEBUG_FORCE_RESET);

	// ----------------------------------------
	// forced reset pulse
	// ----------------------------------------
	reg [2:0] force_cnt_ff; // remaining pulse cycles
	reg [2:0] nxt_force_cnt;

	// start pulse only on a debug write of one in bit zero
	always @* begin
		nxt_force_cnt = force_cnt_ff;
		if (dbg_force_wr && debug_wdata[`FORCE_RESET_BIT]) begin
			nxt_force_cnt = 3'h4;
		end else if (force_cnt_ff != 3'h0) begin
			nxt_force_cnt = force_cnt_ff - 3'h1;
		end
	end

	// pulse counter
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			force_cnt_ff <= 3'h0;
		end else begin
			force_cnt_ff <= nxt_force_cnt;
		end
	end

	assign force_reset_req = (force_cnt_ff != 3'h0);

	// ----------------------------------------
	// options bits
	// ----------------------------------------
	wire [7:0] opt_bits; // assembled options value
	localparam [7:0] OPT_RESET = `OPTIONS_ONE_RESET; // constant reset image, usable as a parameter

	// write-once bits reloaded with OPT_RESET by mcu reset, except reset pin enable (power-on reset only)
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_opt
			if (gi == `OPT_RESERVED4) begin : g_rsv
				assign opt_bits[gi] = 1'b0;
			end else if (gi == `OPT_RESET_PIN_ENABLE) begin : g_por
				// only power-on reset restores this bit
				write_once_bit #(.RESET_VALUE(1'b1)) u_bit (
					.sys_clk(sys_clk),
					.reset_n(por_n),
					.wr_en(opt_wr),
					.wr_data(opt_wdata[gi]),
					.bit_out(opt_bits[gi])
				);
			end else begin : g_mcu
				write_once_bit #(.RESET_VALUE(OPT_RESET[gi])) u_bit (
					.sys_clk(sys_clk),
					.reset_n(reset_n),
					.wr_en(opt_wr),
					.wr_data(opt_wdata[gi]),
					.bit_out(opt_bits[gi])
				);
			end
		end
	endgenerate

	// ----------------------------------------
	// option effects
	// ----------------------------------------
	assign serial_pin_select = opt_bits[`OPT_SERIAL_PIN_SELECT];
	assign serial_on_port_a_pin2_pin3 = serial_pin_select;
	assign timer1_pin_select = opt_bits[`OPT_TIMER1_PIN_SELECT];
	assign timer0_pin_select = opt_bits[`OPT_TIMER0_PIN_SELECT];
	// pin number of each timer zero channel
	assign timer_zero_ch0_pin = timer0_pin_select ? 2'h2 : 2'h0;
	assign timer_zero_ch1_pin = timer0_pin_select ? 2'h3 : 2'h1;
	assign debug_pin_enable = opt_bits[`OPT_DEBUG_PIN_ENABLE];
	assign port_a_pin4_output_only = !debug_pin_enable;
	assign reset_pin_enable = opt_bits[`OPT_RESET_PIN_ENABLE];
	assign fast_wakeup_enable = opt_bits[`OPT_FAST_WAKEUP_ENABLE];
	assign stop_enable = opt_bits[`OPT_STOP_ENABLE];
	// stop with stop disabled becomes illegal reset
	assign stop_enter = stop_exec && stop_enable;
	assign illegal_stop_reset = stop_exec && !stop_enable;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	reg [7:0] nxt_rdata;

	// address decode for cpu reads
	always @* begin
		nxt_rdata = 8'h00;
		if (cpu_addr == `ADDR_DEBUG_FORCE_RESET) begin
			nxt_rdata = `DEBUG_FORCE_RESET_READ;
		end else if (cpu_addr == `ADDR_PART_NUMBER_HIGH) begin
			nxt_rdata = {4'h0, PART_NUMBER[11:8]};
		end else if (cpu_addr == `ADDR_PART_NUMBER_LOW) begin
			nxt_rdata = PART_NUMBER[7:0];
		end else if (cpu_addr == `ADDR_SYSTEM_OPTIONS_ONE) begin
			nxt_rdata = opt_bits;
		end
	end

	// registered read data, valid the cycle after cpu_rd
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_rdata <= 8'h00;
		end else if (cpu_rd) begin
			cpu_rdata <= nxt_rdata;
		end
	end

endmodule // system_debug_id_options

`default_nettype wire

/* include/sys_regs_defines.vh */
`ifndef SYS_REGS_DEFINES_VH
`define SYS_REGS_DEFINES_VH

// register byte addresses
`define ADDR_DEBUG_FORCE_RESET 16'h3001
`define ADDR_PART_NUMBER_HIGH 16'h3002
`define ADDR_PART_NUMBER_LOW 16'h3003
`define ADDR_SYSTEM_OPTIONS_ONE 16'h3004

// debug force reset fields
`define FORCE_RESET_BIT 0
`define DEBUG_FORCE_RESET_READ 8'h00

// system options one fields
`define OPT_SERIAL_PIN_SELECT 7
`define OPT_TIMER1_PIN_SELECT 6
`define OPT_TIMER0_PIN_SELECT 5
`define OPT_RESERVED4 4
`define OPT_DEBUG_PIN_ENABLE 3
`define OPT_RESET_PIN_ENABLE 2
`define OPT_FAST_WAKEUP_ENABLE 1
`define OPT_STOP_ENABLE 0
`define OPTIONS_ONE_RESET 8'h0C

// part number layout
`define PART_NUMBER_HIGH_MASK 8'h0F

// length of the forced reset request pulse
`define FORCE_RESET_PULSE_CYCLES 4

`endif

/* hdl/write_once_bit.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// one write-once option bit
// ----------------------------------------
module write_once_bit #(
	parameter RESET_VALUE = 1'b0
) (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	// write request
	input wire wr_en,
	input wire wr_data,
	// current value
	output wire bit_out
);

	reg bit_ff; // stored value
	reg locked_ff; // high once first write taken
	wire nxt_bit;
	wire nxt_locked;

	// first write after reset sticks, later ones ignored
	assign nxt_bit = (wr_en && !locked_ff) ? wr_data : bit_ff;
	assign nxt_locked = locked_ff | wr_en;

	// state registers
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_ff <= RESET_VALUE;
			locked_ff <= 1'b0;
		end else begin
			bit_ff <= nxt_bit;
			locked_ff <= nxt_locked;
		end
	end

	assign bit_out = bit_ff;

endmodule // write_once_bit

`default_nettype wire

/* tb/sys_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// cpu and debug host driving the register ports
module sys_host_model (
	// clock
	input wire logic sys_clk,
	// register ports
	output logic [15:0] cpu_addr, debug_addr,
	output logic cpu_wr, cpu_rd, debug_wr,
	output logic [7:0] cpu_wdata, debug_wdata
);
	initial {cpu_addr, debug_addr, cpu_wr, cpu_rd, debug_wr, cpu_wdata, debug_wdata} = '0;
	// one strobed cycle; released data lines flip
	task automatic xfer(input logic dbg, wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		if (dbg) begin
			debug_addr <= a;
			debug_wdata <= d;
			debug_wr <= 1'h1;
		end else begin
			cpu_addr <= a;
			cpu_wdata <= d;
			cpu_wr <= wr;
			cpu_rd <= !wr;
		end
		@(posedge sys_clk);
		{cpu_wr, cpu_rd, debug_wr} <= 3'h0;
		cpu_wdata <= ~d;
		debug_wdata <= ~d;
	endtask
endmodule // sys_host_model
`default_nettype wire

/* tb/system_debug_id_options_props.sv */
`timescale 1ns/1ps
`default_nettype none
module system_debug_id_options_props #(parameter [11:0] PART_NUMBER = 12'h000) (
	// watched ports
	input wire sys_clk, reset_n, cpu_rd, cpu_wr, debug_wr, force_reset_req, stop_exec, stop_enable,
	input wire serial_pin_select, serial_on_port_a_pin2_pin3, timer0_pin_select, illegal_stop_reset,
	input wire debug_pin_enable, port_a_pin4_output_only,
	input wire [15:0] cpu_addr, debug_addr,
	input wire [7:0] cpu_rdata, debug_wdata,
	input wire [1:0] timer_zero_ch0_pin, timer_zero_ch1_pin
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// debug host write of one to the force bit
	sequence dbg_force;
		debug_wr && debug_addr == 16'h3001 && debug_wdata[0];
	endsequence
	a_fr_pulse: assert property (dbg_force |=> force_reset_req [*4]) else $error("no reset pulse");
	a_fr_cpu_ignored: assert property (cpu_wr && cpu_addr == 16'h3001 && !debug_wr && !force_reset_req
		|=> !force_reset_req) else $error("cpu forced reset");
	a_fr_read_zero: assert property (cpu_rd && cpu_addr == 16'h3001 |=> cpu_rdata == 8'h00)
		else $error("force reg read");
	a_id_high: assert property (cpu_rd && cpu_addr == 16'h3002 |=> cpu_rdata == {4'h0, PART_NUMBER[11:8]})
		else $error("id high");
	a_id_low: assert property (cpu_rd && cpu_addr == 16'h3003 |=> cpu_rdata == PART_NUMBER[7:0])
		else $error("id low");
	a_serial_route: assert property (serial_on_port_a_pin2_pin3 == serial_pin_select) else $error("serial");
	a_timer0_route: assert property (timer_zero_ch0_pin == {timer0_pin_select, 1'h0} &&
		timer_zero_ch1_pin == {timer0_pin_select, 1'h1}) else $error("timer zero");
	a_debug_pin: assert property (port_a_pin4_output_only == !debug_pin_enable) else $error("pin4");
	a_stop_illegal: assert property (illegal_stop_reset == (stop_exec && !stop_enable)) else $error("stop");
endmodule // system_debug_id_options_props
bind system_debug_id_options system_debug_id_options_props #(.PART_NUMBER(PART_NUMBER)) props (.*);
`default_nettype wire

/* tb/system_debug_id_options_test.sv */
`timescale 1ns/1ps
`default_nettype none
module system_debug_id_options_test;
	logic sys_clk = 1'h0, reset_n = 1'h0, por_n = 1'h0, stop_exec = 1'h0;
	logic [15:0] cpu_addr, debug_addr;
	logic cpu_wr, cpu_rd, debug_wr, force_reset_req, stop_enter, illegal_stop_reset, serial_pin_select;
	logic serial_on_port_a_pin2_pin3, timer1_pin_select, timer0_pin_select, debug_pin_enable;
	logic port_a_pin4_output_only, reset_pin_enable, fast_wakeup_enable, stop_enable;
	logic [7:0] cpu_wdata, debug_wdata, cpu_rdata, w, exp_opt;
	logic [1:0] timer_zero_ch0_pin, timer_zero_ch1_pin;
	logic [15:0] lfsr = 16'hD312;
	int mismatches = 0, n_checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	system_debug_id_options #(.PART_NUMBER(12'h5A7)) dut (.*);
	sys_host_model host (.*);
	task automatic check(input logic [7:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		host.xfer(1'h0, 1'h0, a, 8'h00);
		#1 check(cpu_rdata, exp);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'h1;
		por_n <= 1'h1;
		exp_opt = 8'h0C;
		rd(16'h3001, 8'h00);
		host.xfer(1'h0, 1'h1, 16'h3001, 8'hFF);
		#1 check({7'h0, force_reset_req}, 8'h00);
		host.xfer(1'h1, 1'h1, 16'h3001, 8'hFE);
		#1 check({7'h0, force_reset_req}, 8'h00);
		host.xfer(1'h1, 1'h1, 16'h3001, 8'h01);
		#1 check({7'h0, force_reset_req}, 8'h01);
		host.xfer(1'h0, 1'h1, 16'h3002, 8'hFF);
		rd(16'h3002, 8'h05);
		rd(16'h3003, 8'hA7);
		rd(16'h3005, 8'h00);
		rd(16'h3004, exp_opt);
		for (int i = 0; i < 3; i++) begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			w = lfsr[7:0];
			host.xfer(i[0], 1'h1, 16'h3004, w);
			exp_opt = (w & 8'hEB) | ((i == 0 ? w : exp_opt) & 8'h04);
			host.xfer(1'h0, 1'h1, 16'h3004, ~w);
			rd(16'h3004, exp_opt);
			check({serial_pin_select, timer1_pin_select, timer0_pin_select, 1'h0, debug_pin_enable,
				reset_pin_enable, fast_wakeup_enable, stop_enable}, exp_opt);
			stop_exec <= 1'h1;
			@(posedge sys_clk);
			#1 check({stop_enter, illegal_stop_reset}, {exp_opt[0], !exp_opt[0]});
			stop_exec <= 1'h0;
			reset_n <= 1'h0;
			repeat (2) @(posedge sys_clk);
			reset_n <= 1'h1;
			exp_opt = 8'h08 | (exp_opt & 8'h04);
			rd(16'h3004, exp_opt);
		end
		por_n <= 1'h0;
		reset_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		por_n <= 1'h1;
		reset_n <= 1'h1;
		rd(16'h3004, 8'h0C);
		host.xfer(1'h0, 1'h1, 16'h3004, 8'h00);
		rd(16'h3004, 8'h00);
		final_report();
	end
endmodule // system_debug_id_options_test
`default_nettype wire
